// ### vbs_params.svh
// Register map, field positions, reset values and timing counts of the band select controller.
`ifndef VBS_PARAMS_SVH
`define VBS_PARAMS_SVH

// Register byte addresses.
`define VBS_ADDR_CTRL      8'h00
`define VBS_ADDR_B1_CFG    8'h04
`define VBS_ADDR_B1_FRAC   8'h08
`define VBS_ADDR_B2_CFG    8'h0c
`define VBS_ADDR_B2_FRAC   8'h10
`define VBS_ADDR_READBACK  8'h14
`define VBS_ADDR_CAL       8'h18

// Control register bit positions.
`define VBS_CTRL_RELOCK    0
`define VBS_CTRL_SW        1
`define VBS_CTRL_MODE      2
`define VBS_CTRL_BOTH      3
`define VBS_CTRL_CALEN     4
`define VBS_CTRL_OUT4SEL   5
`define VBS_CTRL_OUT4VAL   6

// Bank configuration fields: LO frequency in MHz and pump current.
`define VBS_CFG_LO_MSB     15
`define VBS_CFG_PUMP_LSB   16
`define VBS_CFG_PUMP_MSB   21

// Reset values and band limits.
`define VBS_PUMP_DEFAULT   6'h1f
`define VBS_PUMP_MAX       6'h3f
`define VBS_CFG_RESET      22'h1f0000
`define VBS_BAND_LAST      7'h7f
`define VBS_BAND_FIRST     7'h00
`define VBS_DIV_LOG2_MIN   3'h1
`define VBS_DIV_LOG2_MAX   3'h5

// Oscillator frequency plan in MHz.
`define VBS_VCO_MIN_MHZ    21'h00a8c
`define VBS_OSC0_TOP_MHZ   21'h00d48
`define VBS_OSC1_TOP_MHZ   21'h00fa0

// Band settling time per capacitance step.
`define VBS_CLK_PERIOD_NS  10
`define VBS_BAND_SETTLE_NS 1000
`define VBS_BAND_SETTLE_CYC ((`VBS_BAND_SETTLE_NS + `VBS_CLK_PERIOD_NS - 1) / `VBS_CLK_PERIOD_NS)

`endif

// ### vbs_pkg.sv
// Types shared by the band select controller.
package vbs_pkg;

  // Band search sequencer states, one-hot.
  typedef enum logic [4:0] {
    VBS_ST_IDLE   = 5'h01,
    VBS_ST_PICK   = 5'h02,
    VBS_ST_SETTLE = 5'h04,
    VBS_ST_JUDGE  = 5'h08,
    VBS_ST_DONE   = 5'h10
  } vbs_state_t;

endpackage : vbs_pkg

// ### vbs_sync3.sv
// Three-stage synchroniser with agreement filter for pin inputs.
`timescale 1ns/1ps
module vbs_sync3 #(
  parameter int WIDTH = 4
) (
  // Clock and reset.
  input  wire logic             sys_clk,
  input  wire logic             resetn,
  // Asynchronous inputs and their filtered copies.
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  genvar i;

  ////////////////////////////////////////////////////////////////////////////
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      logic s1_reg;
      logic s2_reg;
      logic s3_reg;
      logic out_reg;

      // The first stage feeds only the second; a change is taken once stages two and three agree.
      always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
          s1_reg  <= 1'b0;
          s2_reg  <= 1'b0;
          s3_reg  <= 1'b0;
          out_reg <= 1'b0;
        end else begin
          s1_reg <= async_in[i];
          s2_reg <= s1_reg;
          s3_reg <= s2_reg;
          if (s2_reg == s3_reg) begin
            out_reg <= s3_reg;
          end
        end
      end

      assign sync_out[i] = out_reg;
    end
  endgenerate

endmodule // vbs_sync3

// ### vbs_ctrl.sv
// Band select, LO routing and register file of the synthesizer controller.
`timescale 1ns/1ps
`include "vbs_params.svh"
module vbs_ctrl
  import vbs_pkg::*;
(
  // Clock and reset.
  input  wire logic        sys_clk,
  input  wire logic        resetn,
  // AXI4-Lite write channels.
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  output logic [1:0]       s_axi_bresp,
  // AXI4-Lite read channels.
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  input  wire logic [7:0]  s_axi_araddr,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  // Hardware pins and analog status.
  input  wire logic        lo_enable_trigger,
  input  wire logic        mode_pin,
  input  wire logic        lock_window_in,
  input  wire logic        vco_fast_in,
  input  wire logic [5:0]  vco_gain_code,
  // Analog core controls.
  output logic             analog_enable,
  output logic [1:0]       osc_sel,
  output logic [6:0]       band_code_out,
  output logic [2:0]       lo_divide_ratio,
  output logic [23:0]      frac_word_out,
  output logic [5:0]       pump_current_out,
  output logic             mixer1_enable,
  output logic             mixer2_enable,
  output logic             second_synth_bank,
  output logic             search_busy,
  // Status pins.
  output logic             lock_flag,
  output logic             general_output_four
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations.
  logic [3:0]  pin_sync;
  logic        en_s;
  logic        mode_s;
  logic        lock_s;
  logic        fast_s;
  logic        en_d_reg;
  logic        en_rise;
  logic        awready_reg;
  logic        wready_reg;
  logic        bvalid_reg;
  logic [1:0]  bresp_reg;
  logic [7:0]  awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0]  wstrb_reg;
  logic        arready_reg;
  logic        rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0]  rresp_reg;
  logic        wr_fire;
  logic        wr_hit;
  logic [31:0] rd_word;
  logic        rd_hit;
  logic [6:1]  ctrl_reg;
  logic        relock_reg;
  logic [21:0] bank_cfg_reg [0:1];
  logic [23:0] bank_frac_reg [0:1];
  logic [1:0]  bank_hit;
  vbs_state_t  state_reg;
  logic        trig_pend_reg;
  logic        start;
  logic [7:0]  settle_cnt_reg;
  logic [6:0]  band_work_reg;
  logic [6:0]  coarse_band_code_reg;
  logic        coarse_tune_fail_flag_reg;
  logic [5:0]  cal_pump_reg;
  logic [1:0]  osc_sel_reg;
  logic [2:0]  div_log2_reg;
  logic [2:0]  div_log2_calc;
  logic [1:0]  osc_calc;
  logic [20:0] vco_mhz_calc;
  logic [15:0] lo_mhz;
  logic        mode_eff;
  logic        bank_sel_reg;
  logic        mixer1_reg;
  logic        mixer2_reg;
  logic [23:0] frac_out_reg;
  logic [5:0]  pump_out_reg;
  logic        lock_reg;
  logic        out_four_reg;
  logic        analog_en_reg;
  logic        busy_reg;

  // Byte-lane merge for register writes.
  function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[8*b +: 8] = new_v[8*b +: 8];
      end
    end
    return res;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisation and enable edge.
  vbs_sync3 #(.WIDTH(4)) u_sync (
    .sys_clk  (sys_clk),
    .resetn   (resetn),
    .async_in ({vco_fast_in, lock_window_in, mode_pin, lo_enable_trigger}),
    .sync_out (pin_sync)
  );
  assign en_s   = pin_sync[0];
  assign mode_s = pin_sync[1];
  assign lock_s = pin_sync[2];
  assign fast_s = pin_sync[3];
  assign en_rise = en_s & ~en_d_reg;

  // Edge history of the enable pin, which also powers the analog core.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      en_d_reg      <= 1'b0;
      analog_en_reg <= 1'b0;
    end else begin
      en_d_reg      <= en_s;
      analog_en_reg <= en_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write path: address and data are taken in either order.
  assign wr_fire = !awready_reg && !wready_reg && !bvalid_reg;

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      awready_reg <= 1'b1;
      wready_reg  <= 1'b1;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= 2'h0;
      awaddr_reg  <= 8'h00;
      wdata_reg   <= 32'h0;
      wstrb_reg   <= 4'h0;
    end else begin
      if (s_axi_awvalid && awready_reg) begin
        awready_reg <= 1'b0;
        awaddr_reg  <= s_axi_awaddr;
      end else if (bvalid_reg && s_axi_bready) begin
        awready_reg <= 1'b1;
      end
      if (s_axi_wvalid && wready_reg) begin
        wready_reg <= 1'b0;
        wdata_reg  <= s_axi_wdata;
        wstrb_reg  <= s_axi_wstrb;
      end else if (bvalid_reg && s_axi_bready) begin
        wready_reg <= 1'b1;
      end
      if (wr_fire) begin
        bvalid_reg <= 1'b1;
        bresp_reg  <= wr_hit ? 2'h0 : 2'h2;
      end else if (bvalid_reg && s_axi_bready) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  // Writable addresses; read-only ones answer with an error on write.
  assign bank_hit[0] = (awaddr_reg == `VBS_ADDR_B1_CFG) || (awaddr_reg == `VBS_ADDR_B1_FRAC);
  assign bank_hit[1] = (awaddr_reg == `VBS_ADDR_B2_CFG) || (awaddr_reg == `VBS_ADDR_B2_FRAC);
  assign wr_hit = (awaddr_reg == `VBS_ADDR_CTRL) || (|bank_hit);

  // Control bits; the relock request is self clearing and a new write beats the clear.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      ctrl_reg   <= 6'h00;
      relock_reg <= 1'b0;
    end else begin
      if (wr_fire && (awaddr_reg == `VBS_ADDR_CTRL) && wstrb_reg[0]) begin
        ctrl_reg <= wdata_reg[6:1];
      end
      if (wr_fire && (awaddr_reg == `VBS_ADDR_CTRL) && wstrb_reg[0] &&
          wdata_reg[`VBS_CTRL_RELOCK]) begin
        relock_reg <= 1'b1;
      end else if (start) begin
        relock_reg <= 1'b0;
      end
    end
  end

  // Both parameter banks share one write scheme.
  genvar gb;
  generate
    for (gb = 0; gb < 2; gb++) begin : g_bank
      logic [7:0] cfg_addr;
      assign cfg_addr = (gb == 0) ? `VBS_ADDR_B1_CFG : `VBS_ADDR_B2_CFG;
      always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
          bank_cfg_reg[gb]  <= `VBS_CFG_RESET;
          bank_frac_reg[gb] <= 24'h000000;
        end else if (wr_fire && bank_hit[gb]) begin
          if (awaddr_reg == cfg_addr) begin
            bank_cfg_reg[gb] <= 22'(merge({10'h0, bank_cfg_reg[gb]}, wdata_reg, wstrb_reg));
          end else begin
            bank_frac_reg[gb] <= 24'(merge({8'h0, bank_frac_reg[gb]}, wdata_reg, wstrb_reg));
          end
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite read path; unmapped addresses return zero with an error.
  always_comb begin
    rd_hit  = 1'b1;
    rd_word = 32'h0;
    case (s_axi_araddr)
      `VBS_ADDR_CTRL:     rd_word = {25'h0, ctrl_reg, relock_reg};
      `VBS_ADDR_B1_CFG:   rd_word = {10'h0, bank_cfg_reg[0]};
      `VBS_ADDR_B1_FRAC:  rd_word = {8'h0, bank_frac_reg[0]};
      `VBS_ADDR_B2_CFG:   rd_word = {10'h0, bank_cfg_reg[1]};
      `VBS_ADDR_B2_FRAC:  rd_word = {8'h0, bank_frac_reg[1]};
      `VBS_ADDR_READBACK: rd_word = {17'h0, div_log2_reg, busy_reg, osc_sel_reg, lock_reg,
                                     coarse_tune_fail_flag_reg, coarse_band_code_reg};
      `VBS_ADDR_CAL:      rd_word = {26'h0, cal_pump_reg};
      default:            rd_hit  = 1'b0;
    endcase
  end

  // Read data is captured when the address is taken, so it is a snapshot.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      arready_reg <= 1'b1;
      rvalid_reg  <= 1'b0;
      rdata_reg   <= 32'h0;
      rresp_reg   <= 2'h0;
    end else if (s_axi_arvalid && arready_reg) begin
      arready_reg <= 1'b0;
      rvalid_reg  <= 1'b1;
      rdata_reg   <= rd_word;
      rresp_reg   <= rd_hit ? 2'h0 : 2'h2;
    end else if (rvalid_reg && s_axi_rready) begin
      arready_reg <= 1'b1;
      rvalid_reg  <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Divider and oscillator choice from the active bank's LO frequency.
  assign lo_mhz = bank_cfg_reg[bank_sel_reg][`VBS_CFG_LO_MSB:0];

  always_comb begin
    div_log2_calc = `VBS_DIV_LOG2_MAX;
    for (int k = 5; k >= 1; k--) begin
      if (({5'h00, lo_mhz} << k) >= `VBS_VCO_MIN_MHZ) begin
        div_log2_calc = 3'(k);
      end
    end
    vco_mhz_calc = {5'h00, lo_mhz} << div_log2_calc;
    if (vco_mhz_calc < `VBS_OSC0_TOP_MHZ) begin
      osc_calc = 2'h0;
    end else if (vco_mhz_calc < `VBS_OSC1_TOP_MHZ) begin
      osc_calc = 2'h1;
    end else begin
      osc_calc = 2'h2;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Search triggers; an enable edge during a search is held and served afterwards.
  assign start = (state_reg == VBS_ST_IDLE) && (trig_pend_reg || relock_reg);

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      trig_pend_reg <= 1'b0;
    end else if (en_rise) begin
      trig_pend_reg <= 1'b1;
    end else if (start) begin
      trig_pend_reg <= 1'b0;
    end
  end

  // Band search: capacitance is added one step at a time while the oscillator runs fast.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      state_reg      <= VBS_ST_IDLE;
      settle_cnt_reg <= 8'h00;
      band_work_reg  <= `VBS_BAND_FIRST;
      osc_sel_reg    <= 2'h0;
      div_log2_reg   <= `VBS_DIV_LOG2_MIN;
      busy_reg       <= 1'b0;
    end else begin
      case (state_reg)
        VBS_ST_IDLE: begin
          if (start) begin
            state_reg <= VBS_ST_PICK;
            busy_reg  <= 1'b1;
          end
        end
        VBS_ST_PICK: begin
          osc_sel_reg    <= osc_calc;
          div_log2_reg   <= div_log2_calc;
          band_work_reg  <= `VBS_BAND_FIRST;
          settle_cnt_reg <= 8'(`VBS_BAND_SETTLE_CYC - 1);
          state_reg      <= VBS_ST_SETTLE;
        end
        VBS_ST_SETTLE: begin
          if (settle_cnt_reg == 8'h00) begin
            state_reg <= VBS_ST_JUDGE;
          end else begin
            settle_cnt_reg <= settle_cnt_reg - 8'h01;
          end
        end
        VBS_ST_JUDGE: begin
          if (fast_s && (band_work_reg != `VBS_BAND_LAST)) begin
            band_work_reg  <= band_work_reg + 7'h01;
            settle_cnt_reg <= 8'(`VBS_BAND_SETTLE_CYC - 1);
            state_reg      <= VBS_ST_SETTLE;
          end else begin
            state_reg <= VBS_ST_DONE;
          end
        end
        VBS_ST_DONE: begin
          state_reg <= VBS_ST_IDLE;
          busy_reg  <= 1'b0;
        end
        default: begin
          state_reg <= VBS_ST_IDLE;
          busy_reg  <= 1'b0;
        end
      endcase
    end
  end

  // Results are published only when a search completes, never mid-search.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      coarse_band_code_reg      <= `VBS_BAND_FIRST;
      coarse_tune_fail_flag_reg <= 1'b0;
      cal_pump_reg              <= `VBS_PUMP_DEFAULT;
    end else if (state_reg == VBS_ST_DONE) begin
      coarse_band_code_reg      <= band_work_reg;
      coarse_tune_fail_flag_reg <= (band_work_reg == `VBS_BAND_FIRST) ||
                                   (band_work_reg == `VBS_BAND_LAST);
      cal_pump_reg              <= `VBS_PUMP_MAX - vco_gain_code;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Mode picks the bank and mixer; the both-mixer bit enables both mixers.
  assign mode_eff = ctrl_reg[`VBS_CTRL_SW] ? ctrl_reg[`VBS_CTRL_MODE] : mode_s;

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      bank_sel_reg <= 1'b0;
      mixer1_reg   <= 1'b0;
      mixer2_reg   <= 1'b0;
    end else begin
      bank_sel_reg <= mode_eff;
      mixer1_reg   <= ctrl_reg[`VBS_CTRL_BOTH] | ~mode_eff;
      mixer2_reg   <= ctrl_reg[`VBS_CTRL_BOTH] | mode_eff;
    end
  end

  // Active bank words go to the divider and pump; calibration overrides the pump.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      frac_out_reg <= 24'h000000;
      pump_out_reg <= `VBS_PUMP_DEFAULT;
    end else begin
      frac_out_reg <= bank_frac_reg[bank_sel_reg];
      pump_out_reg <= ctrl_reg[`VBS_CTRL_CALEN] ? cal_pump_reg :
                      bank_cfg_reg[bank_sel_reg][`VBS_CFG_PUMP_MSB:`VBS_CFG_PUMP_LSB];
    end
  end

  // Lock follows the window comparator; output four may show it.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      lock_reg     <= 1'b0;
      out_four_reg <= 1'b0;
    end else begin
      lock_reg     <= lock_s;
      out_four_reg <= ctrl_reg[`VBS_CTRL_OUT4SEL] ? lock_s : ctrl_reg[`VBS_CTRL_OUT4VAL];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs.
  assign s_axi_awready       = awready_reg;
  assign s_axi_wready        = wready_reg;
  assign s_axi_bvalid        = bvalid_reg;
  assign s_axi_bresp         = bresp_reg;
  assign s_axi_arready       = arready_reg;
  assign s_axi_rvalid        = rvalid_reg;
  assign s_axi_rdata         = rdata_reg;
  assign s_axi_rresp         = rresp_reg;
  assign analog_enable       = analog_en_reg;
  assign osc_sel             = osc_sel_reg;
  assign band_code_out       = band_work_reg;
  assign lo_divide_ratio     = div_log2_reg;
  assign frac_word_out       = frac_out_reg;
  assign pump_current_out    = pump_out_reg;
  assign mixer1_enable       = mixer1_reg;
  assign mixer2_enable       = mixer2_reg;
  assign second_synth_bank   = bank_sel_reg;
  assign search_busy         = busy_reg;
  assign lock_flag           = lock_reg;
  assign general_output_four = out_four_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Checks.
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  sequence s_search_begin;
    (state_reg == VBS_ST_PICK) ##1 (state_reg == VBS_ST_SETTLE) && (band_work_reg == 7'h00);
  endsequence

  sequence s_step_taken;
    (state_reg == VBS_ST_SETTLE) && (settle_cnt_reg == 8'(`VBS_BAND_SETTLE_CYC - 1));
  endsequence

  a_search_start: assert property (start |=> s_search_begin)
    else $error("search did not start after trigger");
  a_relock_clear: assert property (start && !wr_fire |=> !relock_reg)
    else $error("relock request not cleared at start");
  a_band_step: assert property ((state_reg == VBS_ST_JUDGE) && fast_s && band_work_reg != 7'h7f
      |=> s_step_taken and (band_work_reg == $past(band_work_reg) + 7'h01))
    else $error("band step not taken");
  a_code_at_end: assert property ($changed(coarse_band_code_reg)
      |-> $past(state_reg) == VBS_ST_DONE)
    else $error("band code changed outside completion");
  a_fail_edge: assert property ((state_reg == VBS_ST_DONE) &&
      (band_work_reg == 7'h00 || band_work_reg == 7'h7f) |=> coarse_tune_fail_flag_reg)
    else $error("edge band code did not flag failure");
  a_pass_mid: assert property ((state_reg == VBS_ST_DONE) && band_work_reg != 7'h00 &&
      band_work_reg != 7'h7f |=> !coarse_tune_fail_flag_reg)
    else $error("mid band code flagged failure");
  a_osc_legal: assert property (osc_sel_reg != 2'h3)
    else $error("oscillator select out of range");
  a_div_range: assert property (div_log2_reg >= 3'h1 && div_log2_reg <= 3'h5)
    else $error("divide ratio out of range");
  a_both_mixers: assert property (ctrl_reg[`VBS_CTRL_BOTH] |=> mixer1_reg && mixer2_reg)
    else $error("both-mixer bit did not enable both mixers");
  a_bank_table: assert property (!ctrl_reg[`VBS_CTRL_BOTH] && !mode_eff
      |=> mixer1_reg && !mixer2_reg && !bank_sel_reg)
    else $error("mode low did not select bank one and mixer one");
  a_bank_high: assert property (!ctrl_reg[`VBS_CTRL_BOTH] && mode_eff
      |=> !mixer1_reg && mixer2_reg && bank_sel_reg)
    else $error("mode high did not select bank two and mixer two");
  a_frac_active: assert property (##1 frac_out_reg == $past(bank_frac_reg[bank_sel_reg]))
    else $error("fractional word not from active bank");
  a_pump_override: assert property (ctrl_reg[`VBS_CTRL_CALEN]
      |=> pump_out_reg == $past(cal_pump_reg))
    else $error("calibrated pump current not applied");
  a_lock_pin: assert property (ctrl_reg[`VBS_CTRL_OUT4SEL]
      |=> out_four_reg == lock_reg)
    else $error("output four does not show lock");

endmodule // vbs_ctrl

// ### vbs_analog_model.sv
// Behavioural model of the oscillator core and lock window detector.
`timescale 1ns/1ps
module vbs_analog_model (
  // Search progress and the band the bench wants found.
  input  wire logic       search_busy,
  input  wire logic [6:0] band_code_out,
  input  wire logic [6:0] target_band,
  // Status returned to the controller.
  output logic            vco_fast_in,
  output logic            lock_window_in,
  output logic [5:0]      vco_gain_code
);
  // Runs fast until enough capacitance steps are switched in.
  assign vco_fast_in = band_code_out < target_band;
  // The tuning voltage sits in the window only once the search is over.
  assign lock_window_in = !search_busy;
  // Gain follows the wanted band, so each search calibrates a different pump current.
  assign vco_gain_code = target_band[5:0];
endmodule // vbs_analog_model

// ### synth_vco_band_select_ctrl_tb.sv
// Self-checking bench for the band select controller.
`timescale 1ns/1ps
`include "vbs_params.svh"
module synth_vco_band_select_ctrl_tb;
  localparam int LIM = 20000;
  logic        sys_clk, resetn, awvalid, wvalid, bready, arvalid, rready, enable, mode;
  logic        awready, wready, bvalid, rvalid, arready, fast, lock_win, busy, m1, m2, bank2;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, seed;
  logic [1:0]  bresp, rresp, osc;
  logic [6:0]  target, band;
  logic [5:0]  pump, pump_out, gain;
  logic [23:0] frac, frac_out;
  logic [2:0]  div;
  logic        aen, lock, out4;
  logic [33:0] q[$];
  int          err_count, samples_checked;
  vbs_ctrl u_dut (.sys_clk(sys_clk), .resetn(resetn), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_awaddr(awaddr), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_bresp(bresp), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_araddr(araddr), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .lo_enable_trigger(enable), .mode_pin(mode), .lock_window_in(lock_win),
    .vco_fast_in(fast), .vco_gain_code(gain), .analog_enable(aen), .osc_sel(osc),
    .band_code_out(band), .lo_divide_ratio(div), .frac_word_out(frac_out),
    .pump_current_out(pump_out), .mixer1_enable(m1), .mixer2_enable(m2),
    .second_synth_bank(bank2), .search_busy(busy), .lock_flag(lock),
    .general_output_four(out4));
  vbs_analog_model u_core (.search_busy(busy), .band_code_out(band), .target_band(target),
    .vco_fast_in(fast), .lock_window_in(lock_win), .vco_gain_code(gain));
  ////////////////////////////////////////////////////////////////////////////////
  // Compare one value and count it.
  task automatic check(input string what, input logic [33:0] seen, input logic [33:0] want);
    samples_checked++;
    if (seen !== want) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", what, want, seen);
    end
  endtask
  // Print the counts and the verdict, then stop.
  task automatic end_of_test();
    $display("mismatches %0d comparisons %0d", err_count, samples_checked);
    if (err_count == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // A wait that used its whole bound means the design hung.
  task automatic give_up(input int n);
    if (n >= LIM) begin
      err_count++;
      end_of_test();
    end
  endtask
  // One write; bready is held until the response is seen.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge sys_clk);
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    awaddr <= a;
    wdata <= d;
    for (n = 0; n < LIM && !bvalid; n++) begin
      @(posedge sys_clk);
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
    end
    bready <= 1'h0;
    give_up(n);
  endtask
  // One read; the expected response and data are queued for the monitor.
  task automatic rd(input logic [7:0] a, input logic [33:0] e);
    int n;
    q.push_back(e);
    @(posedge sys_clk);
    arvalid <= 1'h1;
    rready <= 1'h1;
    araddr <= a;
    for (n = 0; n < LIM && !rvalid; n++) begin
      @(posedge sys_clk);
      if (arready) arvalid <= 1'h0;
    end
    rready <= 1'h0;
    give_up(n);
  endtask
  // Start a search by pin or by relock bit, wait it out, then read the result.
  task automatic search(input logic [6:0] t, input logic pin);
    int n;
    logic fail;
    fail = (t == 7'h00) || (t == 7'h7f);
    target = t;
    if (pin) enable <= 1'h1;
    else wr(`VBS_ADDR_CTRL, 32'h11);
    for (n = 0; n < LIM && !busy; n++) @(posedge sys_clk);
    give_up(n);
    for (n = 0; n < LIM && busy; n++) @(posedge sys_clk);
    give_up(n);
    check("enable", aen, pin);
    enable <= 1'h0;
    // Lets the lock status cross the pin filter before it is read.
    repeat (10) @(posedge sys_clk);
    rd(`VBS_ADDR_READBACK, {2'h0, 32'h1100 | {24'h0, fail, t}});
    check("pump", pump_out, `VBS_PUMP_MAX - t[5:0]);
    check("divider", {osc, div}, 5'h01);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Every completed read is matched against the oldest note.
  always @(posedge sys_clk) begin
    if (rvalid && rready) check("read", {rresp, rdata}, q.pop_front());
  end
  // Free-running system clock.
  initial begin
    sys_clk = 1'h0;
    forever #5 sys_clk = ~sys_clk;
  end
  // Main sequence.
  initial begin
    {resetn, awvalid, wvalid, bready, arvalid, rready, enable, mode} = 8'h00;
    {awaddr, araddr, wdata, target} = 55'h0;
    seed = 32'h0abdf2d4;
    repeat (6) @(posedge sys_clk);
    resetn <= 1'h1;
    rd(`VBS_ADDR_CTRL, 34'h0);
    rd(`VBS_ADDR_B1_CFG, 34'h001f0000);
    rd(8'h40, 34'h200000000);
    pump = 6'($random(seed));
    frac = 24'($random(seed));
    wr(`VBS_ADDR_B1_CFG, {10'h0, pump, 16'h05dc});
    wr(`VBS_ADDR_B1_FRAC, {8'h0, frac});
    rd(`VBS_ADDR_B1_CFG, {12'h0, pump, 16'h05dc});
    repeat (8) @(posedge sys_clk);
    check("pump", pump_out, pump);
    check("frac", frac_out, frac);
    search(7'h05, 1'h0);
    search(7'h00, 1'h1);
    search(7'h7e, 1'h1);
    search(7'h7f, 1'h0);
    // Odd steps ask for mode high; from step four software owns the mode and the pin is inverted.
    for (int i = 0; i < 8; i++) begin
      mode <= i[0] ^ i[2];
      wr(`VBS_ADDR_CTRL, {25'h0, i[0], i[1], 1'h0, i[1], i[0], i[2], 1'h0});
      repeat (8) @(posedge sys_clk);
      check("mixer1", m1, !i[0] || i[1]);
      check("mixer2", m2, i[0] || i[1]);
      check("bank", bank2, i[0]);
      check("lock", lock, 1'h1);
      check("output four", out4, i[0] | i[1]);
    end
    end_of_test();
  end
endmodule // synth_vco_band_select_ctrl_tb
